// [rtl/layout_pkg.sv]
// constants for the state-save layout calculator
package layout_pkg;
  localparam int REG_ADDR_W = 8; // register byte address width
  localparam int NUM_COMP = 63; // components tracked, bitmap bits 62:0
  localparam int IDX_W = 6; // component index width
  // fixed area layout, byte offsets from the area base
  localparam logic [31:0] LEGACY_BASE = 32'h0000_0000;
  localparam logic [31:0] LEGACY_SIZE = 32'h0000_0200;
  localparam logic [31:0] HEADER_OFF = 32'h0000_0200;
  localparam logic [31:0] HEADER_SIZE = 32'h0000_0040;
  localparam logic [31:0] EXT_OFF = 32'h0000_0240;
  localparam logic [31:0] ALIGN_ADD = 32'h0000_003f;
  localparam logic [31:0] ALIGN_MASK = 32'hffff_ffc0;
  localparam logic [IDX_W-1:0] FIRST_EXT = 6'h02; // lowest extended comp
  localparam int FMT_BIT = 63; // compaction bitmap format bit
  // legacy and header byte boundaries (exclusive upper ends)
  localparam logic [15:0] B_FP_LO_END = 16'h0018;
  localparam logic [15:0] B_SIMD_LO_END = 16'h0020;
  localparam logic [15:0] B_FP_HI_END = 16'h00a0;
  localparam logic [15:0] B_SIMD_HI_END = 16'h01a0;
  localparam logic [15:0] B_RSVD_END = 16'h01d0;
  localparam logic [15:0] B_LEGACY_END = 16'h0200;
  localparam logic [15:0] B_PRESENT_END = 16'h0208;
  localparam logic [15:0] B_COMPACT_END = 16'h0210;
  localparam logic [15:0] B_HEADER_END = 16'h0240;
  // byte class codes
  localparam logic [3:0] CLS_FP = 4'h0;
  localparam logic [3:0] CLS_SIMD = 4'h1;
  localparam logic [3:0] CLS_LEG_RSVD = 4'h2;
  localparam logic [3:0] CLS_LEG_UNUSED = 4'h3;
  localparam logic [3:0] CLS_PRESENT_BM = 4'h4;
  localparam logic [3:0] CLS_COMPACT_BM = 4'h5;
  localparam logic [3:0] CLS_HDR_RSVD = 4'h6;
  localparam logic [3:0] CLS_EXTENDED = 4'h7;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_PRESENT_LO = 8'h08;
  localparam logic [7:0] A_PRESENT_HI = 8'h0c;
  localparam logic [7:0] A_COMPACT_LO = 8'h10;
  localparam logic [7:0] A_COMPACT_HI = 8'h14;
  localparam logic [7:0] A_USER_LO = 8'h18;
  localparam logic [7:0] A_USER_HI = 8'h1c;
  localparam logic [7:0] A_SUP_LO = 8'h20;
  localparam logic [7:0] A_SUP_HI = 8'h24;
  localparam logic [7:0] A_SEL = 8'h28;
  localparam logic [7:0] A_SIZE = 8'h2c;
  localparam logic [7:0] A_STD_OFF = 8'h30;
  localparam logic [7:0] A_ALIGN = 8'h34;
  localparam logic [7:0] A_RES_OFF = 8'h38;
  localparam logic [7:0] A_RES_VALID = 8'h3c;
  localparam logic [7:0] A_EXT_SIZE = 8'h40;
  localparam logic [7:0] A_TOTAL = 8'h44;
  localparam logic [7:0] A_PROBE = 8'h48;
  localparam logic [7:0] A_CLASS = 8'h4c;
  // status bit positions and bus responses
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_COMPACT = 2;
  localparam int ST_SUPPORT = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  // scan phases, gray along idle-scan-done
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SCAN = 2'b01,
    PH_DONE = 2'b11
  } phase_e;
endpackage : layout_pkg

// [rtl/ext_slot_place.sv]
// placement of one component in the compacted extended region
`timescale 1ns/1ps
`default_nettype none
module ext_slot_place (
  input wire logic first,
  input wire logic align,
  input wire logic [31:0] prev_end,
  output logic [31:0] loc
);
  import layout_pkg::*;
  logic [31:0] rounded; // prev_end lifted to a 64-byte boundary

  // chain from the previous end, optionally rounded up
  always_comb begin
    rounded = (prev_end + ALIGN_ADD) & ALIGN_MASK;
    if (first) begin
      loc = EXT_OFF;
    end else if (align) begin
      loc = rounded;
    end else begin
      loc = prev_end;
    end
  end
endmodule : ext_slot_place
`default_nettype wire

// [rtl/state_save_layout_calc.sv]
// state-save area layout calculator with an axi4-lite register port
// Notes on behaviour
// - legacy region is bytes 0 to 511
// - fp stack state uses bytes 23:0, 159:32
// - packed simd uses bytes 31:24, 415:160
// - bytes 511:464 unused, 463:416 reserved
// - header is 64 bytes at offset 512
// - header bytes 7:0 hold present bitmap
// - header bytes 15:8 compaction bitmap, bit63 format
// - bit 63 selects compacted restore variant
// - header bytes 63:16 are reserved
// - extended region at 576, size follows masks
// - only components two and up are extended
// - standard always, compacted only if supported
// - standard offsets and sizes come from table
// - compacted absent components take no space
// - first compacted component sits at 576
// - unaligned component follows previous one directly
// - aligned component rounds up to 64 bytes
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module state_save_layout_calc #(
  parameter int N = layout_pkg::NUM_COMP, // tracked components
  parameter bit COMPACT_SUPPORT = 1'b1 // compaction extensions present
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [layout_pkg::REG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [layout_pkg::REG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import layout_pkg::*;

  localparam int SCAN_MAX = 70; // upper bound on scan length in cycles

  // all block state in one record
  typedef struct packed {
    logic awready; // bus handshake outputs
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held; // write address taken, waiting for data
    logic w_held; // write data taken, waiting for address
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [63:0] present_bm; // present_component_bitmap image
    logic [63:0] compaction_bm; // compaction_bitmap image
    logic [63:0] user_mask; // user_component_enable_mask
    logic [63:0] sup_mask; // supervisor_component_enable_mask
    logic [IDX_W-1:0] sel; // table window index
    logic [N-1:0][31:0] sizes; // enumerated sizes
    logic [N-1:0][31:0] std_off; // enumerated standard offsets
    logic [N-1:0] align; // enumerated alignment flags
    logic [N-1:0][31:0] res_off; // computed offsets
    logic [N-1:0] res_valid; // offset reported for component
    phase_e phase; // scan sequencer
    logic [IDX_W-1:0] idx; // component under scan
    logic [31:0] run_end; // running end of the extended region
    logic first; // no compacted component placed yet
    logic compacted; // format chosen for this scan
    logic [31:0] ext_size; // extended region size
    logic [31:0] total; // whole area size
    logic [15:0] probe; // byte offset to classify
    logic [3:0] byte_class; // class of probe byte
  } st_s;

  st_s st; // registered state
  st_s next_st; // next state
  logic [31:0] place_loc; // compacted placement of idx
  logic [63:0] enable_mask; // combined enable masks

  assign enable_mask = st.user_mask | st.sup_mask;

  // compacted chaining arithmetic
  ext_slot_place u_place (
    .first(st.first),
    .align(st.align[st.idx]),
    .prev_end(st.run_end),
    .loc(place_loc)
  );

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // what a byte of the area is used for
  function automatic logic [3:0] classify(input logic [15:0] p);
    logic [3:0] c;
    c = CLS_EXTENDED;
    if (p < B_FP_LO_END) begin
      c = CLS_FP;
    end else if (p < B_SIMD_LO_END) begin
      c = CLS_SIMD;
    end else if (p < B_FP_HI_END) begin
      c = CLS_FP;
    end else if (p < B_SIMD_HI_END) begin
      c = CLS_SIMD;
    end else if (p < B_RSVD_END) begin
      c = CLS_LEG_RSVD;
    end else if (p < B_LEGACY_END) begin
      c = CLS_LEG_UNUSED;
    end else if (p < B_PRESENT_END) begin
      c = CLS_PRESENT_BM;
    end else if (p < B_COMPACT_END) begin
      c = CLS_COMPACT_BM;
    end else if (p < B_HEADER_END) begin
      c = CLS_HDR_RSVD;
    end
    return c;
  endfunction : classify

  // next-state logic: bus slave, register file, scan
  always_comb begin
    logic [31:0] rd;
    logic [31:0] comp_end;
    logic present;
    logic start;
    logic [IDX_W-1:0] cur;
    logic [31:0] pw; // merged probe word before narrowing
    rd = '0;
    pw = '0;
    comp_end = '0;
    present = 1'b0;
    start = 1'b0;
    cur = st.idx;
    next_st = st;
    // write address and data taken in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    // response retired
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // both halves present: perform the write
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      unique case (st.awaddr)
        A_CTRL: begin
          start = st.wstrb[0] && st.wdata[0];
        end
        A_PRESENT_LO: begin
          next_st.present_bm[31:0] =
            merge(st.present_bm[31:0], st.wdata, st.wstrb);
        end
        A_PRESENT_HI: begin
          next_st.present_bm[63:32] =
            merge(st.present_bm[63:32], st.wdata, st.wstrb);
        end
        A_COMPACT_LO: begin
          next_st.compaction_bm[31:0] =
            merge(st.compaction_bm[31:0], st.wdata, st.wstrb);
        end
        A_COMPACT_HI: begin
          next_st.compaction_bm[63:32] =
            merge(st.compaction_bm[63:32], st.wdata, st.wstrb);
        end
        A_USER_LO: begin
          next_st.user_mask[31:0] =
            merge(st.user_mask[31:0], st.wdata, st.wstrb);
        end
        A_USER_HI: begin
          next_st.user_mask[63:32] =
            merge(st.user_mask[63:32], st.wdata, st.wstrb);
        end
        A_SUP_LO: begin
          next_st.sup_mask[31:0] =
            merge(st.sup_mask[31:0], st.wdata, st.wstrb);
        end
        A_SUP_HI: begin
          next_st.sup_mask[63:32] =
            merge(st.sup_mask[63:32], st.wdata, st.wstrb);
        end
        A_SEL: begin
          if (st.wstrb[0]) begin
            next_st.sel = st.wdata[IDX_W-1:0];
          end
        end
        A_SIZE: begin
          if (int'(st.sel) < N) begin
            next_st.sizes[st.sel] =
              merge(st.sizes[st.sel], st.wdata, st.wstrb);
          end
        end
        A_STD_OFF: begin
          if (int'(st.sel) < N) begin
            next_st.std_off[st.sel] =
              merge(st.std_off[st.sel], st.wdata, st.wstrb);
          end
        end
        A_ALIGN: begin
          if ((int'(st.sel) < N) && st.wstrb[0]) begin
            next_st.align[st.sel] = st.wdata[1]; // flag sits at bit 1
          end
        end
        A_PROBE: begin
          pw = merge({16'h0000, st.probe}, st.wdata, st.wstrb);
          next_st.probe = pw[15:0]; // probe keeps the low half only
        end
        A_STATUS, A_RES_OFF, A_RES_VALID, A_EXT_SIZE, A_TOTAL,
        A_CLASS: begin
          next_st.bresp = RESP_OKAY; // read-only, write ignored
        end
        default: begin
          next_st.bresp = RESP_DECERR; // unmapped
        end
      endcase
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    // read channel: answer one cycle after the address is taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        A_CTRL: rd = '0;
        A_STATUS: begin
          rd[ST_BUSY] = (st.phase == PH_SCAN);
          rd[ST_DONE] = (st.phase == PH_DONE);
          rd[ST_COMPACT] = st.compacted;
          rd[ST_SUPPORT] = COMPACT_SUPPORT;
        end
        A_PRESENT_LO: rd = st.present_bm[31:0];
        A_PRESENT_HI: rd = st.present_bm[63:32];
        A_COMPACT_LO: rd = st.compaction_bm[31:0];
        A_COMPACT_HI: rd = st.compaction_bm[63:32];
        A_USER_LO: rd = st.user_mask[31:0];
        A_USER_HI: rd = st.user_mask[63:32];
        A_SUP_LO: rd = st.sup_mask[31:0];
        A_SUP_HI: rd = st.sup_mask[63:32];
        A_SEL: rd = {26'h0, st.sel};
        A_SIZE: rd = (int'(st.sel) < N) ? st.sizes[st.sel] : '0;
        A_STD_OFF: rd = (int'(st.sel) < N) ? st.std_off[st.sel] : '0;
        A_ALIGN: rd = {30'h0, (int'(st.sel) < N) && st.align[st.sel], 1'b0};
        A_RES_OFF: rd = (int'(st.sel) < N) ? st.res_off[st.sel] : '0;
        A_RES_VALID: rd = {31'h0, (int'(st.sel) < N) && st.res_valid[st.sel]};
        A_EXT_SIZE: rd = st.ext_size;
        A_TOTAL: rd = st.total;
        A_PROBE: rd = {16'h0000, st.probe};
        A_CLASS: rd = {28'h0, st.byte_class};
        default: begin
          rd = '0;
          next_st.rresp = RESP_DECERR; // unmapped
        end
      endcase
      next_st.rdata = rd;
    end
    next_st.arready = !next_st.rvalid;
    // probe classification tracks the probe register
    next_st.byte_class = classify(st.probe);
    // scan sequencer
    unique case (st.phase)
      PH_IDLE, PH_DONE: begin
        if (start) begin
          next_st.phase = PH_SCAN;
          next_st.idx = FIRST_EXT;
          next_st.run_end = EXT_OFF;
          next_st.first = 1'b1;
          next_st.res_valid = '0;
          // bit 63 chooses the format only where compaction exists
          next_st.compacted = st.compaction_bm[FMT_BIT] &&
                              COMPACT_SUPPORT;
        end
      end
      PH_SCAN: begin
        present = st.compacted ? st.compaction_bm[cur]
                               : enable_mask[cur];
        if (present && st.compacted) begin
          next_st.res_off[cur] = place_loc;
          next_st.res_valid[cur] = 1'b1;
          next_st.run_end = place_loc + st.sizes[cur];
          next_st.first = 1'b0;
        end else if (present) begin
          next_st.res_off[cur] = st.std_off[cur];
          next_st.res_valid[cur] = 1'b1;
          comp_end = st.std_off[cur] + st.sizes[cur];
          if (comp_end > st.run_end) begin
            next_st.run_end = comp_end;
          end
        end
        if (int'(cur) == N - 1) begin
          next_st.phase = PH_DONE;
        end else begin
          next_st.idx = cur + 6'h01;
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase
    // sizes follow the running end once the scan ends
    if (st.phase == PH_DONE) begin
      next_st.ext_size = st.run_end - EXT_OFF;
      next_st.total = st.run_end;
    end
  end

  // state register, cleared by synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;

  // both write halves held, response not yet raised
  sequence s_both_held;
    st.aw_held && st.w_held && !st.bvalid;
  endsequence

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
      s_both_held |=> st.bvalid && !st.aw_held && !st.w_held;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response not raised after both halves");

  property p_read_resp;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && st.arready) |=> st.rvalid && !st.arready;
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("read answer missing one cycle after address");

  property p_low_invalid;
    @(posedge aclk) disable iff (!aresetn)
      st.res_valid[1:0] == 2'b00;
  endproperty
  a_low_invalid: assert property (p_low_invalid)
    else $error("offset reported for component below two");

  property p_absent;
    @(posedge aclk) disable iff (!aresetn)
      (st.phase == PH_SCAN && st.compacted) |=>
        st.res_valid[$past(st.idx)] == $past(st.compaction_bm[st.idx]);
  endproperty
  a_absent: assert property (p_absent)
    else $error("compacted presence differs from bitmap");

  property p_variant;
    @(posedge aclk) disable iff (!aresetn)
      (st.phase != PH_SCAN && $past(st.phase) == PH_SCAN) |->
        st.compacted == $past(st.compacted);
  endproperty
  a_variant: assert property (p_variant)
    else $error("format changed during scan");

  property p_start_fmt;
    @(posedge aclk) disable iff (!aresetn)
      (st.phase != PH_SCAN) ##1 (st.phase == PH_SCAN) |->
        st.compacted == ($past(st.compaction_bm[FMT_BIT])
                         && COMPACT_SUPPORT);
  endproperty
  a_start_fmt: assert property (p_start_fmt)
    else $error("format not taken from bit 63");

  property p_first_at_ext;
    @(posedge aclk) disable iff (!aresetn)
      (st.phase == PH_SCAN && st.compacted && st.first
       && st.compaction_bm[st.idx]) |=> st.res_off[$past(st.idx)] == EXT_OFF;
  endproperty
  a_first_at_ext: assert property (p_first_at_ext)
    else $error("first compacted component not at 576");

  property p_aligned;
    @(posedge aclk) disable iff (!aresetn)
      (st.phase == PH_SCAN && st.compacted && !st.first
       && st.align[st.idx]) |->
        place_loc[5:0] == 6'h00 && place_loc >= st.run_end
        && place_loc < st.run_end + 32'h0000_0040;
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("aligned component not on next 64-byte boundary");

  property p_packed;
    @(posedge aclk) disable iff (!aresetn)
      (st.phase == PH_SCAN && st.compacted && !st.first
       && !st.align[st.idx]) |-> place_loc == st.run_end;
  endproperty
  a_packed: assert property (p_packed)
    else $error("unaligned component not directly after previous");

  property p_scan_ends;
    @(posedge aclk) disable iff (!aresetn)
      (st.phase != PH_SCAN) ##1 (st.phase == PH_SCAN) |->
        ##[1:SCAN_MAX] (st.phase == PH_DONE);
  endproperty
  a_scan_ends: assert property (p_scan_ends)
    else $error("scan did not finish in time");

  property p_class;
    @(posedge aclk) disable iff (!aresetn)
      (st.probe < B_FP_LO_END && $stable(st.probe)) |=>
        st.byte_class == CLS_FP;
  endproperty
  a_class: assert property (p_class)
    else $error("low legacy byte not classed as fp state");
endmodule : state_save_layout_calc
`default_nettype wire

// [tb/comp_table.sv]
// far-side model: per-component sizes, standard offsets, align flags
`timescale 1ns/1ps
`default_nettype none
module comp_table (
  input wire logic [5:0] idx,
  output logic [31:0] size,
  output logic [31:0] std_off,
  output logic align
);
  // uneven sizes so rounding matters; standard slots 1 KiB apart
  always_comb begin
    size = 32'(idx) * 32'h18 + 32'h8;
    std_off = 32'h240 + (32'(idx) << 10); // 64-byte multiples
    align = idx[0] ^ idx[2];
  end
endmodule : comp_table
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the layout calculator
`timescale 1ns/1ps
`default_nettype none
module tb;
  import layout_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, size, soff;
  logic awready, wready, bvalid, arready, rvalid, algn;
  logic [1:0] bresp, rresp;
  logic [5:0] idx = 0;
  logic [33:0] exp_q[$]; // expected {resp, data}
  int miscompares = 0, samples_checked = 0, cyc = 0, seed = 32'he448;
  int bnd[10] = '{0, 24, 32, 160, 416, 464, 512, 520, 528, 576};
  localparam logic [34:0] SKIP = 35'h400000000; // poll, no note
  state_save_layout_calc i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  comp_table i_tbl (.idx(idx), .size(size), .std_off(soff), .align(algn));
  always #4 aclk = ~aclk;
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] e);
    samples_checked++;
    if (got !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  // watcher: oldest note against each answer
  always @(posedge aclk) begin
    if (rvalid && rready && exp_q.size() > 0)
      chk({rresp, rdata}, exp_q.pop_front());
    if (bvalid && bready && exp_q.size() > 0)
      chk({bresp, 32'h0}, exp_q.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [34:0] e,
                    output logic [31:0] v);
    @(posedge aclk);
    if (!e[34]) exp_q.push_back(e[33:0]);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    v = rdata;
    rready <= 0;
  endtask : rd
  function automatic logic [3:0] cls(input logic [15:0] p);
    if (p < 24 || (p >= 32 && p < 160)) return CLS_FP;
    if (p < 416) return CLS_SIMD;
    if (p < 464) return CLS_LEG_RSVD;
    if (p < 512) return CLS_LEG_UNUSED;
    if (p < 520) return CLS_PRESENT_BM;
    if (p < 528) return CLS_COMPACT_BM;
    if (p < 576) return CLS_HDR_RSVD;
    return CLS_EXTENDED;
  endfunction : cls
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    logic [31:0] d, loc, last, mx;
    logic [63:0] bm, um, sm;
    logic first, en;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    wr(8'hfc, 32'h1, RESP_DECERR);
    rd(8'hfc, {1'b0, RESP_DECERR, 32'h0}, d);
    wr(A_TOTAL, 32'h1);
    // byte classes at both sides of each region edge, then random
    for (int k = 0; k < 30; k++) begin
      logic [15:0] p;
      p = (k < 20) ? 16'(bnd[k/2] - k % 2) : 16'($random(seed) & 1023);
      wr(A_PROBE, {16'h0, p});
      rd(A_CLASS, {3'b0, 28'h0, cls(p)}, d);
    end
    $display("test byte classes done");
    for (int i = 2; i < 63; i++) begin
      idx <= 6'(i);
      wr(A_SEL, 32'(i));
      wr(A_SIZE, size);
      wr(A_STD_OFF, soff);
      wr(A_ALIGN, {30'h0, algn, 1'b0});
    end
    // compacted, standard, compacted with nothing above bit 1
    for (int ps = 0; ps < 3; ps++) begin
      bm = {$random(seed), $random(seed)};
      um = {$random(seed), $random(seed)};
      sm = {$random(seed), $random(seed)};
      bm[63] = (ps != 1);
      if (ps == 2) bm = 64'h8000_0000_0000_0003;
      if (!i_dut.COMPACT_SUPPORT) bm = 64'h0;
      wr(A_COMPACT_LO, bm[31:0]);
      wr(A_COMPACT_HI, bm[63:32]);
      rd(A_COMPACT_HI, {3'b0, bm[63:32]}, d);
      wr(A_PRESENT_LO, um[31:0]);
      rd(A_PRESENT_LO, {3'b0, um[31:0]}, d);
      wr(A_USER_LO, um[31:0]);
      wr(A_USER_HI, um[63:32]);
      wr(A_SUP_LO, sm[31:0]);
      wr(A_SUP_HI, sm[63:32]);
      wr(A_CTRL, 32'h1);
      do rd(A_STATUS, SKIP, d); while (!d[ST_DONE]);
      rd(A_STATUS, {3'b0, 28'h0, 1'b1, bm[63], 2'b10}, d);
      first = 1;
      last = 576;
      mx = 576;
      for (int i = 0; i < 63; i++) begin
        idx <= 6'(i);
        wr(A_SEL, 32'(i));
        en = (i >= 2) && (bm[63] ? bm[i] : (um[i] | sm[i]));
        rd(A_RES_VALID, {3'b0, 31'h0, en}, d);
        if (en) begin
          loc = !bm[63] ? soff : first ? 576 :
                algn ? ((last + 63) & ALIGN_MASK) : last;
          rd(A_RES_OFF, {3'b0, loc}, d);
          last = loc + size;
          if (last > mx) mx = last;
          first = 0;
        end
      end
      rd(A_EXT_SIZE, {3'b0, mx - 32'd576}, d);
      rd(A_TOTAL, {3'b0, mx}, d);
      $display("test layout pass %0d done", ps);
    end
    end_sim();
  end
endmodule : tb
`default_nettype wire
